// ---- pmrd_checker_asserts.sv ----
// assertions on the program memory read port
`include "pmrd_defines.vh"
module pmrd_checker (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire err_o,
  input wire flash_rd_o,
  input wire core_skip_o,
  input wire busy_o
);
  wire take = cyc_i && stb_i && !ack_o && !err_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  bus_answer_a: assert property (take |=> ack_o ^ err_o)
    else $error("no single answer");
  unmapped_err_a: assert property (take && adr_i > `PMRD_STATUS_ADDR |=> err_o)
    else $error("unmapped not refused");
  fetch_timing_a: assert property (take && we_i && adr_i == `PMRD_CONTROL_ADDR && sel_i[0] && dat_i[0]
    && !busy_o |-> ##2 flash_rd_o) else $error("fetch late");
  skip_pair_a: assert property (core_skip_o == flash_rd_o)
    else $error("skip apart from fetch");
  busy_clear_a: assert property ($rose(busy_o) |-> ##1 flash_rd_o ##1 !busy_o)
    else $error("busy not cleared");
  fetch_quiet_a: assert property (flash_rd_o |-> $past(busy_o))
    else $error("stray fetch");
  high_zero_a: assert property (ack_o && !we_i && adr_i == `PMRD_ADDR_HIGH_ADDR |-> dat_o[31:5] == 27'h0)
    else $error("high bits set");
endmodule
bind pmrd_program_memory_read_port pmrd_checker chk_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .flash_rd_o, .core_skip_o, .busy_o);

// ---- pmrd_defines.vh ----
// register offsets, field positions, reset values and timing for the program memory read port
`ifndef PMRD_DEFINES_VH
`define PMRD_DEFINES_VH

// register byte addresses on the wishbone bus
`define PMRD_CONTROL_ADDR 8'h00
`define PMRD_ADDR_LOW_ADDR 8'h04
`define PMRD_ADDR_HIGH_ADDR 8'h08
`define PMRD_DATA_LOW_ADDR 8'h0C
`define PMRD_DATA_HIGH_ADDR 8'h10
`define PMRD_STATUS_ADDR 8'h14
`define PMRD_ADDR_DECODE_W 8

// control register fields
`define PMRD_CTRL_START_BIT 0
`define PMRD_CTRL_RESERVED_BIT 7
`define PMRD_CTRL_RESET 8'h80
`define PMRD_CTRL_RESERVED_RESET 1'b1

// address and word layout
`define PMRD_ADDR_W 13
`define PMRD_ADDR_HIGH_W 5
`define PMRD_WORD_W 14
`define PMRD_DATA_HIGH_W 6

// read takes two instruction cycles after the start write
`define PMRD_READ_CYCLES 2
`define PMRD_CNT_W 2
`define PMRD_CNT_ONE 2'h1

// controller states
`define PMRD_ST_IDLE 2'h0
`define PMRD_ST_WAIT 2'h1
`define PMRD_ST_FETCH 2'h2

`endif

// ---- pmrd_flash_model.sv ----
// flash array model answering fetches from the read port
module pmrd_flash_model (
  // fetch side
  input wire logic [12:0] addr_i,
  input wire logic rd_i,
  // word out
  output logic [13:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [13:0] word = {addr_i[5:0], addr_i[12:5]} ^ 14'h2A5B;
  // inverted outside a fetch so a late sample is caught
  assign data_o = rd_i ? word : ~word;
endmodule

// ---- pmrd_program_memory_read_port.v ----
// program memory read port: wishbone registers and a two-cycle flash fetch sequencer
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`include "pmrd_defines.vh"

module pmrd_program_memory_read_port (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg err_o,
  // flash array port
  output reg [`PMRD_ADDR_W-1:0] flash_addr_o,
  output reg flash_rd_o,
  input wire [`PMRD_WORD_W-1:0] flash_data_i,
  // core side
  input wire code_protect_i,
  output reg core_skip_o,
  output wire busy_o
);

  localparam ST_IDLE = `PMRD_ST_IDLE;
  localparam ST_WAIT = `PMRD_ST_WAIT;
  localparam ST_FETCH = `PMRD_ST_FETCH;

  // sequencer state
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [`PMRD_CNT_W-1:0] cnt_reg;
  reg [`PMRD_CNT_W-1:0] cnt_next;

  // control and status bits
  reg start_reg;
  reg start_next;
  reg reserved_reg;
  reg protect_seen_reg;

  // address pair, unknown until written
  reg [7:0] addr_low_reg;
  reg [7:0] addr_low_next;
  reg [`PMRD_ADDR_HIGH_W-1:0] addr_high_reg;
  reg [`PMRD_ADDR_HIGH_W-1:0] addr_high_next;

  // data pair, unknown until the first fetch
  reg [7:0] data_low_reg;
  reg [7:0] data_low_next;
  reg [`PMRD_DATA_HIGH_W-1:0] data_high_reg;
  reg [`PMRD_DATA_HIGH_W-1:0] data_high_next;

  // fetch outputs
  reg fetch_rd_next;
  reg skip_next;
  reg [`PMRD_ADDR_W-1:0] fetch_addr_next;

  // bus answer
  reg ack_next;
  reg err_next;
  reg [31:0] rdata_next;

  // address decode, one bit per register
  reg [5:0] hit_vec;

  wire req = cyc_i & stb_i & ~ack_o & ~err_o;
  wire lane0 = sel_i[0];
  wire wr = req & we_i & lane0;
  wire hit_ctrl = hit_vec[0];
  wire hit_low = hit_vec[1];
  wire hit_high = hit_vec[2];
  wire hit_dlow = hit_vec[3];
  wire hit_dhigh = hit_vec[4];
  wire hit_stat = hit_vec[5];
  wire mapped = |hit_vec;
  // address writes dropped mid-fetch so the word always matches the address
  wire low_wr = wr & hit_low & ~start_reg;
  wire high_wr = wr & hit_high & ~start_reg;
  wire start_wr = wr & hit_ctrl & dat_i[`PMRD_CTRL_START_BIT] & (state_reg == ST_IDLE);
  wire fetch_done = (state_reg == ST_FETCH);

  // read views, zero extended so unimplemented bits read as zero
  wire [31:0] ctrl_view = {24'h000000, reserved_reg, 6'h00, start_reg};
  wire [31:0] low_view = {24'h000000, addr_low_reg};
  wire [31:0] high_view = {27'h0000000, addr_high_reg};
  wire [31:0] dlow_view = {24'h000000, data_low_reg};
  wire [31:0] dhigh_view = {26'h0000000, data_high_reg};
  wire [31:0] stat_view = {30'h00000000, protect_seen_reg, start_reg};
  wire [31:0] rd_mux;

  assign busy_o = start_reg;

  always @* begin
    hit_vec = 6'h00;
    case (adr_i)
      `PMRD_CONTROL_ADDR: begin
        hit_vec[0] = 1'b1;
      end
      `PMRD_ADDR_LOW_ADDR: begin
        hit_vec[1] = 1'b1;
      end
      `PMRD_ADDR_HIGH_ADDR: begin
        hit_vec[2] = 1'b1;
      end
      `PMRD_DATA_LOW_ADDR: begin
        hit_vec[3] = 1'b1;
      end
      `PMRD_DATA_HIGH_ADDR: begin
        hit_vec[4] = 1'b1;
      end
      `PMRD_STATUS_ADDR: begin
        hit_vec[5] = 1'b1;
      end
      default: begin
        hit_vec = 6'h00;
      end
    endcase
  end

  // one and-or term per data bit
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_rd_bit
      assign rd_mux[gi] = (hit_ctrl & ctrl_view[gi])
        | (hit_low & low_view[gi])
        | (hit_high & high_view[gi])
        | (hit_dlow & dlow_view[gi])
        | (hit_dhigh & dhigh_view[gi])
        | (hit_stat & stat_view[gi]);
    end
  endgenerate

  // sequencer: start write, one idle cycle, fetch in the second cycle
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_wr) begin
          state_next = ST_WAIT;
          cnt_next = `PMRD_CNT_ONE;
        end
      end
      ST_WAIT: begin
        if (cnt_reg == `PMRD_CNT_ONE) begin
          state_next = ST_FETCH;
        end else begin
          cnt_next = cnt_reg - `PMRD_CNT_ONE;
        end
      end
      ST_FETCH: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= {`PMRD_CNT_W{1'b0}};
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // strobe and skip share one cycle; protection never gates the read
  always @* begin
    fetch_rd_next = 1'b0;
    skip_next = 1'b0;
    fetch_addr_next = {addr_high_reg, addr_low_reg};
    if (state_next == ST_FETCH) begin
      fetch_rd_next = 1'b1;
      skip_next = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      flash_rd_o <= 1'b0;
    end else begin
      flash_rd_o <= fetch_rd_next;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      flash_addr_o <= {`PMRD_ADDR_W{1'b0}};
    end else begin
      flash_addr_o <= fetch_addr_next;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      core_skip_o <= 1'b0;
    end else begin
      core_skip_o <= skip_next;
    end
  end

  // status copy only; the flash fetch never looks at it, only status reads do
  always @(posedge clk_i) begin
    if (rst_i) begin
      protect_seen_reg <= 1'b0;
    end else begin
      protect_seen_reg <= code_protect_i;
    end
  end

  // set by software, cleared by hardware on the same edge as the data load
  always @* begin
    start_next = start_reg;
    if (start_wr) begin
      start_next = 1'b1;
    end else if (fetch_done) begin
      start_next = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= start_next;
    end
  end

  // reserved bit reads one and ignores writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      reserved_reg <= `PMRD_CTRL_RESERVED_RESET;
    end
  end

  always @* begin
    addr_low_next = addr_low_reg;
    addr_high_next = addr_high_reg;
    if (low_wr) begin
      addr_low_next = dat_i[7:0];
    end
    if (high_wr) begin
      addr_high_next = dat_i[`PMRD_ADDR_HIGH_W-1:0];
    end
  end

  always @* begin
    data_low_next = data_low_reg;
    data_high_next = data_high_reg;
    if (fetch_done) begin
      data_low_next = flash_data_i[7:0];
      data_high_next = flash_data_i[`PMRD_WORD_W-1:8];
    end
  end

  // no reset here: these registers start unknown
  always @(posedge clk_i) begin
    addr_low_reg <= addr_low_next;
  end

  always @(posedge clk_i) begin
    addr_high_reg <= addr_high_next;
  end

  always @(posedge clk_i) begin
    data_low_reg <= data_low_next;
  end

  always @(posedge clk_i) begin
    data_high_reg <= data_high_next;
  end

  // answer one cycle after the take; unmapped offsets get an error
  always @* begin
    ack_next = 1'b0;
    err_next = 1'b0;
    rdata_next = 32'h00000000;
    if (req) begin
      if (mapped) begin
        ack_next = 1'b1;
      end else begin
        err_next = 1'b1;
      end
      if (~we_i) begin
        rdata_next = rd_mux;
      end
    end
  end

  // answer flags are single-cycle pulses, since req masks the next take
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= ack_next;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      err_o <= 1'b0;
    end else begin
      err_o <= err_next;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else begin
      dat_o <= rdata_next;
    end
  end

endmodule

// ---- tb_top.sv ----
// self-checking bench for the program memory read port
`include "pmrd_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, code_protect_i = 0;
  logic [7:0] adr_i = 8'h0;
  logic [31:0] dat_i = 32'h0, dat_o, seed = 32'hA2CBA04B;
  logic ack_o, err_o, flash_rd_o, core_skip_o, busy_o;
  logic [12:0] flash_addr_o;
  logic [13:0] flash_data_i, w;
  logic [32:0] exp_q[$];
  int fail_count = 0, num_checks = 0;
  always #25 clk_i = ~clk_i;
  pmrd_program_memory_read_port pmrd_program_memory_read_port_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i(4'hF), .dat_i, .dat_o, .ack_o, .err_o, .flash_addr_o, .flash_rd_o, .flash_data_i,
    .code_protect_i, .core_skip_o, .busy_o);
  pmrd_flash_model pmrd_flash_model_i (.addr_i(flash_addr_o), .rd_i(flash_rd_o), .data_o(flash_data_i));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic compare(input logic [32:0] e, a);
    num_checks++;
    if (a !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  // one classic cycle; read results are noted for the monitor
  task automatic bus(input logic wr, input logic [7:0] a, d, input logic [32:0] e);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= wr;
    adr_i <= a;
    dat_i <= {24'h0, d};
    if (!wr) exp_q.push_back(e);
    do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  always @(posedge clk_i)
    if ((ack_o | err_o) === 1'b1 && we_i === 1'b0)
      compare(exp_q.pop_front(), {err_o, err_o ? 32'h0 : dat_o});
  initial begin
    repeat (2000) @(posedge clk_i);
    fail_count++;
    conclude();
  end
  initial begin
    logic [7:0] h, l;
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    bus(0, `PMRD_CONTROL_ADDR, 8'h0, 33'h80);
    bus(0, 8'h18, 8'h0, 33'h100000000);
    repeat (6) begin
      seed = xs(seed);
      h = seed[7:0];
      l = seed[15:8];
      code_protect_i <= seed[16];
      bus(1, `PMRD_ADDR_HIGH_ADDR, h, 33'h0);
      bus(1, `PMRD_ADDR_LOW_ADDR, l, 33'h0);
      bus(0, `PMRD_ADDR_HIGH_ADDR, 8'h0, 33'(h[4:0]));
      bus(0, `PMRD_ADDR_LOW_ADDR, 8'h0, 33'(l));
      bus(1, `PMRD_CONTROL_ADDR, 8'h1, 33'h0);
      repeat (3) @(posedge clk_i);
      w = {l[5:0], h[4:0], l[7:5]} ^ 14'h2A5B;
      bus(0, `PMRD_DATA_LOW_ADDR, 8'h0, 33'(w[7:0]));
      bus(0, `PMRD_DATA_HIGH_ADDR, 8'h0, 33'(w[13:8]));
      bus(0, `PMRD_CONTROL_ADDR, 8'h0, 33'h80);
      bus(0, `PMRD_STATUS_ADDR, 8'h0, {31'h0, seed[16], 1'b0});
    end
    conclude();
  end
endmodule
